// ---- tb/tcq_monitor.sv ----
/* tcq_monitor: port assertions for tcq_top.
   assumes a bind by name from the bench. */
`timescale 1ns/100ps
`default_nettype none
module tcq_monitor
	import tcq_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire tcq_pin_type pins,
	input wire logic trace_we,
	input wire tcq_rec_type trace_rec,
	input wire logic halt,
	input wire logic irq
);
default clocking @(posedge pclk); endclocking
default disable iff (!presetn);
////////////////////////////////////////////////////////////////
a_rdy_one_wait: assert property (psel && penable && !pready |=> pready)
	else $error("pready late");
a_rdy_pulse: assert property (pready |=> !pready)
	else $error("pready held");
a_err_unmapped: assert property (pready && paddr > OFS_RDHI |-> pslverr)
	else $error("no pslverr");
a_err_rdata: assert property (pready && pslverr |-> prdata == '0)
	else $error("error read not zero");
a_we_pulse: assert property (trace_we |=> !trace_we)
	else $error("trace_we held");
a_we_after_cyc: assert property (
	trace_we |-> $past(pins.cyc_tgl, 3) != $past(pins.cyc_tgl, 4))
	else $error("record off cycle");
a_rec_payload: assert property (
	trace_we |-> trace_rec[47:8] == {$past(pins.addr, 3), $past(pins.data, 3)})
	else $error("record payload");
// resume is the only way out of a break
a_halt_held: assert property (
	halt && !(pready && pwrite && paddr == OFS_CTRL) |=> halt)
	else $error("halt dropped");
a_halt_on_cyc: assert property (
	$rose(halt) |-> $past(pins.cyc_tgl, 3) != $past(pins.cyc_tgl, 4))
	else $error("halt off cycle");
endmodule // tcq_monitor
`default_nettype wire

// ---- tb/tcq_target.sv ----
/* tcq_target: target bus model, one bus cycle per go pulse.
   assumes go pulses at least 8 pclk apart. */
`timescale 1ns/100ps
`default_nettype none
module tcq_target
	import tcq_pkg::*;
(
	input wire logic pclk,
	input wire logic go,
	input wire tcq_pin_type nxt,
	output tcq_pin_type pins
);
logic step = 0;
initial pins = '0;
// fields settle a pclk before the toggle, held until the next cycle
// no timeout states; dhit only for bus accesses
always @(posedge pclk) begin
	step <= go;
	if (go)
		pins <= {pins.cyc_tgl, nxt[72:0]};
	if (step)
		pins.cyc_tgl <= !pins.cyc_tgl;
end
endmodule // tcq_target
`default_nettype wire

// ---- tb/tcq_top_tb_top.sv ----
/* tcq_top_tb_top: self-checking bench for tcq_top.
   assumes tcq_target drives the pins. */
`timescale 1ns/100ps
`default_nettype none
module tcq_top_tb_top;
import tcq_pkg::*;
logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, go = 0;
logic [7:0] paddr = '0;
logic [31:0] pwdata = '0, prdata;
logic pready, pslverr, trace_we, halt, irq, win;
tcq_pin_type pins, nxt = '0;
tcq_rec_type trace_rec, first;
tcq_rec_type q_rec[$];
logic [32:0] q_rd[$];
logic [8:0] runs[10] = '{9'h040, 9'h091, 9'h0D6, 9'h058, 9'h05D,
	9'h048, 9'h0CC, 9'h062, 9'h110, 9'h15C};
int mismatches = 0, compares = 0, kept, aux;
always #2.5 pclk = !pclk;
// short break delay keeps the run small
tcq_top #(.DELAY_UNIT(4)) dut_u (.*);
tcq_target tgt_u (.pclk(pclk), .go(go), .nxt(nxt), .pins(pins));
////////////////////////////////////////////////////////////////
task automatic print_verdict;
	$display("compares %0d mismatches %0d", compares, mismatches);
	if (mismatches == 0 && compares > 0)
		$display("No errors found");
	else
		$display("Errors were found");
	$finish;
endtask
task automatic chk(input logic [47:0] got, input logic [47:0] exp);
	compares++;
	if (got !== exp) begin
		mismatches++;
		$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
	end
endtask
// an x expectation flags a record nobody asked for
always @(posedge pclk) begin
	if (trace_we)
		chk(trace_rec, q_rec.size() > 0 ? q_rec.pop_front() : 'x);
	if (pready && !pwrite)
		chk({pslverr, prdata}, q_rd.pop_front());
end
task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
	int n;
	@(posedge pclk);
	psel <= 1;
	pwrite <= w;
	paddr <= a;
	pwdata <= d;
	@(posedge pclk);
	penable <= 1;
	n = 0;
	do begin
		@(posedge pclk);
		n++;
	end while (!pready && n < 20);
	if (!pready) begin
		mismatches++;
		print_verdict();
	end
	psel <= 0;
	penable <= 0;
endtask
task automatic rd(input logic [7:0] a, input logic [32:0] e);
	q_rd.push_back(e);
	apb(0, a, 0);
endtask
function automatic logic [7:0] evn(input logic [15:0] e);
	for (int i = 0; i < 16; i++)
		if (e[i])
			return {4'h1, 4'(i)};
	return 8'h0;
endfunction
task automatic cyc(input tcq_pin_type p, input logic keep);
	tcq_rec_type r;
	r = {p.addr, p.data, aux == 1 ? p.task_id : aux == 2 ? {7'h0, p.ext} : evn(p.ev)};
	if (keep && kept == 0)
		first = r;
	if (keep)
		q_rec.push_back(r);
	kept += 32'(keep);
	nxt <= p;
	go <= 1;
	@(posedge pclk);
	go <= 0;
	repeat (7) @(posedge pclk);
endtask
////////////////////////////////////////////////////////////////
task automatic run(input logic [8:0] c);
	tcq_pin_type p;
	logic k, inw;
	aux = int'(c[1:0]);
	kept = 0;
	win = 0;
	apb(1, OFS_CTRL, {22'h0, c[1:0], c[2], c[5:3], 1'b0, c[8:6]});
	repeat (8) begin
		p = '0;
		p.addr = 24'($urandom % 16);
		p.data = 16'($urandom);
		p.ev = 16'($urandom) & 16'h000E;
		p.dhit = 1'($urandom);
		p.task_id = 8'($urandom);
		p.ext = 1'($urandom);
		inw = (win | p.ev[1]) & !p.ev[2];
		win = inw;
		case (c[5:3])
			TCQ_Q_BETWEEN: k = inw ^ c[2];
			TCQ_Q_DUR: k = p.ev[3] ^ c[2];
			TCQ_Q_SUB: k = (p.ev[3] && p.addr inside {[4:9]}) ^ c[2];
			TCQ_Q_DATA: k = p.dhit;
			default: k = 1;
		endcase
		cyc(p, k || c[8:6] > 3);
	end
	rd(OFS_WPTR, {25'h0, 8'(kept)});
	apb(1, OFS_RIDX, 0);
	if (kept > 0)
		repeat (2) rd(OFS_RDLO, {1'b0, first.data, 8'h0, first.aux});
	$display("run %h done", c);
endtask
task automatic tp(input logic [6:0] x, input logic h);
	tcq_pin_type p;
	p = '0;
	p.exc = x;
	cyc(p, 1);
	chk(halt, h);
endtask
initial begin
	void'($urandom(32'hd2b36958));
	repeat (5) @(posedge pclk);
	presetn <= 1;
	rd(OFS_CTRL, 33'h1);
	rd(8'hFC, 33'h1_0000_0000);
	apb(1, OFS_EVSEL, 32'h321);
	apb(1, OFS_ALO, 32'h4);
	apb(1, OFS_AHI, 32'h9);
	foreach (runs[i])
		run(runs[i]);
	aux = 0;
	apb(1, OFS_CTRL, 32'h2);
	// fill until full: the 257th bus cycle finds memory full
	for (int i = 0; i < 257; i++)
		cyc(74'({$urandom, $urandom, $urandom}), i < 256);
	rd(OFS_WPTR, 33'h100);
	rd(OFS_STAT, 33'h4);
	$display("fill done");
	apb(1, OFS_MASK, 32'h3);
	for (int k = 0; k < 7; k++) begin
		apb(1, OFS_CTRL, 32'h8000_0003 | (k == 0 ? 32'h400 : 32'h0));
		apb(1, OFS_TPEN, 32'h1 << (16 + k));
		tp(7'h7F & ~(7'h1 << k), 0);
		tp(7'h1 << k, k > 0);
		// one delay unit is four further bus cycles
		if (k == 0) begin
			repeat (3) tp(0, 0);
			tp(0, 1);
		end
		chk(irq, 1);
		rd(OFS_STAT, 33'h3);
		rd(OFS_STAT, 33'h0);
		chk(irq, 0);
		$display("exception %0d done", k);
	end
	print_verdict();
end
initial begin
	repeat (30000) @(posedge pclk);
	mismatches++;
	print_verdict();
end
endmodule // tcq_top_tb_top
bind tcq_top tcq_monitor mon_u (.*);
`default_nettype wire

// ---- verilog/tcq_pkg.sv ----
/*
 * tcq_pkg: register map, field layout, reset values, modes and carriers
 * of the trace capture qualifier.
 * assumes a 32-bit apb slave and a 200 MHz pclk.
 */
`default_nettype none
package tcq_pkg;
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_EVSEL = 8'h04;
	localparam logic [7:0] OFS_TPEN = 8'h08;
	localparam logic [7:0] OFS_ALO = 8'h0C;
	localparam logic [7:0] OFS_AHI = 8'h10;
	localparam logic [7:0] OFS_STAT = 8'h14;
	localparam logic [7:0] OFS_MASK = 8'h18;
	localparam logic [7:0] OFS_WPTR = 8'h1C;
	localparam logic [7:0] OFS_RIDX = 8'h20;
	localparam logic [7:0] OFS_RDLO = 8'h24;
	localparam logic [7:0] OFS_RDHI = 8'h28;
	// ctrl field positions
	localparam int CTRL_MODE = 0;
	localparam int CTRL_QSEL = 4;
	localparam int CTRL_QDEL = 7;
	localparam int CTRL_AUX = 8;
	localparam int CTRL_DLY = 10;
	localparam int CTRL_RESUME = 31;
	// evsel field positions
	localparam int EV_START = 0;
	localparam int EV_END = 4;
	localparam int EV_DUR = 8;
	// tpen field positions
	localparam int TP_EXC = 16;
	// status bits
	localparam int ST_TP = 0;
	localparam int ST_HALT = 1;
	localparam int ST_FULL = 2;
	localparam int ST_W = 3;
	localparam int MEM_AW = 8;
	localparam int MEM_DEPTH = 256;
	localparam int DLY_W = 23;
	localparam logic [2:0] RST_DLY = 3'h0;
	localparam logic [1:0] RST_AUX = 2'h0;
	localparam logic [2:0] RST_MODE = 3'h1;
	typedef enum logic [2:0] {
		TCQ_M_STOP = 3'h1, TCQ_M_FULL = 3'h2, TCQ_M_AROUND = 3'h3,
		TCQ_M_RSTOP = 3'h4, TCQ_M_RFULL = 3'h5
	} tcq_mode_type;
	typedef enum logic [2:0] {
		TCQ_Q_NONE = 3'h0, TCQ_Q_BETWEEN = 3'h1, TCQ_Q_DUR = 3'h2,
		TCQ_Q_SUB = 3'h3, TCQ_Q_DATA = 3'h4
	} tcq_qsel_type;
	typedef enum logic [1:0] {
		TCQ_AUX_EVNUM = 2'h0, TCQ_AUX_TASK = 2'h1, TCQ_AUX_EXT = 2'h2
	} tcq_aux_type;
	typedef enum logic [1:0] {
		TCQ_S_IDLE = 2'b00, TCQ_S_COUNT = 2'b01, TCQ_S_HALT = 2'b11
	} tcq_state_type;
	typedef struct packed {
		logic cyc_tgl;
		logic [23:0] addr;
		logic [15:0] data;
		logic [15:0] ev;
		logic [6:0] exc;
		logic dhit;
		logic [7:0] task_id;
		logic ext;
	} tcq_pin_type;
	typedef struct packed {
		logic [23:0] addr;
		logic [15:0] data;
		logic [7:0] aux;
	} tcq_rec_type;
endpackage
`default_nettype wire

// ---- verilog/tcq_top.sv ----
/*
 * tcq_top: trace capture qualifier with apb registers, trace memory,
 * trace-point detection and delayed program break.
 * assumes target pins are asynchronous to pclk; cyc_tgl toggles once per
 * target bus cycle and the other pins are steady around that toggle.
 */
// The APB interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module tcq_top
	import tcq_pkg::*;
#(
	parameter int DELAY_UNIT = 1048576
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire tcq_pin_type pins,
	output logic trace_we,
	output tcq_rec_type trace_rec,
	output logic halt,
	output logic irq
);

	////////////////////////////////////////////////////////////////////
	typedef struct packed {
		tcq_pin_type s1;
		tcq_pin_type s2;
		logic tgl_d;
		logic [31:0] ctrl;
		logic [15:0] evsel;
		logic [22:0] tpen;
		logic [23:0] alo;
		logic [23:0] ahi;
		logic [ST_W-1:0] stat;
		logic [ST_W-1:0] mask;
		logic [MEM_AW-1:0] ridx;
		logic [MEM_AW-1:0] wptr;
		logic full;
		logic win;
		tcq_state_type st;
		logic [DLY_W-1:0] cnt;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic we;
		tcq_rec_type rec;
		logic halt;
		logic irq;
	} tcq_regs_type;

	tcq_regs_type r;
	tcq_regs_type next_r;
	tcq_rec_type mem [MEM_DEPTH];
	tcq_rec_type mem_rd;

	function automatic logic [4:0] tcq_evnum(input logic [15:0] ev);
		logic [4:0] n;
		n = 5'h00;
		for (int i = 15; i >= 0; i--) begin
			if (ev[i]) begin
				n = {1'b1, 4'(i)};
			end
		end
		return n;
	endfunction

	////////////////////////////////////////////////////////////////////
	logic cyc;
	logic tp;
	logic in_rng;
	logic ev_dur;
	logic ev_start;
	logic ev_end;
	logic win_now;
	logic hit;
	logic keep;
	logic acc;
	logic rd_stat;
	tcq_mode_type mode;
	tcq_qsel_type qsel;
	logic [2:0] dly;
	logic [ST_W-1:0] ev_set;
	logic full_set;
	wire logic [6:0] exc_hit;

	assign mem_rd = mem[r.ridx];

	// one enable per exceptional condition
	for (genvar g = 0; g < 7; g++) begin : g_exc
		assign exc_hit[g] = r.s2.exc[g] & r.tpen[TP_EXC + g];
	end

	always_comb begin
		next_r = r;
		// first stage is read only by the second
		next_r.s1 = pins;
		next_r.s2 = r.s1;
		next_r.tgl_d = r.s2.cyc_tgl;
		cyc = r.s2.cyc_tgl ^ r.tgl_d;
		mode = tcq_mode_type'(r.ctrl[CTRL_MODE +: 3]);
		qsel = tcq_qsel_type'(r.ctrl[CTRL_QSEL +: 3]);
		dly = r.ctrl[CTRL_DLY +: 3];
		// codes above four act as four, the longest delay
		if (dly > 3'h4) begin
			dly = 3'h4;
		end
		acc = psel & penable & r.pready;
		rd_stat = acc & ~pwrite & (paddr == OFS_STAT);

		// trace point: enabled events or enabled exceptions
		tp = cyc & ((|(r.s2.ev & r.tpen[15:0])) | (|exc_hit));

		////////////////////////////////////////////////////////////////
		// qualifier terms
		ev_start = r.s2.ev[r.evsel[EV_START +: 4]];
		ev_end = r.s2.ev[r.evsel[EV_END +: 4]];
		ev_dur = r.s2.ev[r.evsel[EV_DUR +: 4]];
		in_rng = (r.s2.addr >= r.alo) & (r.s2.addr <= r.ahi);
		win_now = (r.win | ev_start) & ~ev_end;
		unique case (qsel)
			TCQ_Q_BETWEEN: hit = win_now;
			TCQ_Q_DUR: hit = ev_dur;
			TCQ_Q_SUB: hit = ev_dur & in_rng;
			TCQ_Q_DATA: hit = r.s2.dhit;
			default: hit = 1'b1;
		endcase
		if (qsel == TCQ_Q_NONE || qsel > TCQ_Q_DATA) begin
			keep = 1'b1;
		end else if (mode == TCQ_M_STOP || mode == TCQ_M_FULL
			|| mode == TCQ_M_AROUND) begin
			// data-access has no deletion form
			keep = (r.ctrl[CTRL_QDEL] && qsel != TCQ_Q_DATA) ? ~hit : hit;
		end else begin
			keep = 1'b1;
		end
		if (cyc) begin
			// the window moves only on bus cycles
			next_r.win = win_now;
		end

		////////////////////////////////////////////////////////////////
		// recording
		next_r.we = 1'b0;
		full_set = 1'b0;
		next_r.rec.addr = r.s2.addr;
		next_r.rec.data = r.s2.data;
		unique case (tcq_aux_type'(r.ctrl[CTRL_AUX +: 2]))
			TCQ_AUX_TASK: next_r.rec.aux = r.s2.task_id;
			TCQ_AUX_EXT: next_r.rec.aux = {7'h00, r.s2.ext};
			default: next_r.rec.aux = {3'h0, tcq_evnum(r.s2.ev)};
		endcase
		if (cyc && keep && !r.full) begin
			next_r.we = 1'b1;
			next_r.wptr = r.wptr + 1'b1;
			// stop-on-full modes freeze at the last entry
			if (r.wptr == MEM_AW'(MEM_DEPTH - 1)
				&& (mode == TCQ_M_FULL || mode == TCQ_M_RFULL)) begin
				next_r.full = 1'b1;
				full_set = 1'b1;
			end
		end

		////////////////////////////////////////////////////////////////
		// delayed break
		unique case (r.st)
			TCQ_S_IDLE: begin
				if (tp) begin
					if (dly == 3'h0) begin
						next_r.st = TCQ_S_HALT;
						next_r.halt = 1'b1;
					end else begin
						next_r.st = TCQ_S_COUNT;
						next_r.cnt = DLY_W'(dly * DELAY_UNIT);
					end
				end
			end
			TCQ_S_COUNT: begin
				if (cyc) begin
					next_r.cnt = r.cnt - 1'b1;
					if (r.cnt == DLY_W'(1)) begin
						next_r.st = TCQ_S_HALT;
						next_r.halt = 1'b1;
					end
				end
			end
			TCQ_S_HALT: begin
				if (acc && pwrite && paddr == OFS_CTRL
					&& pwdata[CTRL_RESUME]) begin
					next_r.st = TCQ_S_IDLE;
					next_r.halt = 1'b0;
				end
			end
			default: begin
				// an unused code falls back to idle
				next_r.st = TCQ_S_IDLE;
				next_r.halt = 1'b0;
			end
		endcase

		////////////////////////////////////////////////////////////////
		// apb: one wait state, answer in the second access cycle
		next_r.pready = psel & penable & ~r.pready;
		next_r.pslverr = 1'b0;
		next_r.prdata = 32'h0000_0000;
		if (psel && penable && !r.pready) begin
			unique case (paddr)
				OFS_CTRL: next_r.prdata = {1'b0, r.ctrl[30:0]};
				OFS_EVSEL: next_r.prdata = {16'h0000, r.evsel};
				OFS_TPEN: next_r.prdata = {9'h000, r.tpen};
				OFS_ALO: next_r.prdata = {8'h00, r.alo};
				OFS_AHI: next_r.prdata = {8'h00, r.ahi};
				OFS_STAT: next_r.prdata = {29'h0, r.stat};
				OFS_MASK: next_r.prdata = {29'h0, r.mask};
				OFS_WPTR: next_r.prdata = {23'h0, r.full, r.wptr};
				OFS_RIDX: next_r.prdata = {24'h0, r.ridx};
				// plain reads; stored records stay untouched
				OFS_RDLO: next_r.prdata = {mem_rd.data, 8'h00, mem_rd.aux};
				OFS_RDHI: next_r.prdata = {8'h00, mem_rd.addr};
				default: next_r.pslverr = 1'b1;
			endcase
		end
		if (acc && pwrite) begin
			unique case (paddr)
				OFS_CTRL: begin
					next_r.ctrl = {1'b0, pwdata[30:0]};
					// any ctrl write restarts acquisition, mode changed or not
					next_r.wptr = '0;
					next_r.full = 1'b0;
					next_r.win = 1'b0;
					// a cycle seen at the restart is dropped
					next_r.we = 1'b0;
				end
				OFS_EVSEL: next_r.evsel = pwdata[15:0];
				OFS_TPEN: next_r.tpen = pwdata[22:0];
				OFS_ALO: next_r.alo = pwdata[23:0];
				OFS_AHI: next_r.ahi = pwdata[23:0];
				OFS_MASK: next_r.mask = pwdata[ST_W-1:0];
				OFS_RIDX: next_r.ridx = pwdata[MEM_AW-1:0];
				default: ;
			endcase
		end

		// sticky status, read clears, a new event wins
		ev_set = '0;
		ev_set[ST_TP] = tp;
		ev_set[ST_HALT] = next_r.halt & ~r.halt;
		// full event counts even when a restart clears full
		ev_set[ST_FULL] = full_set;
		next_r.stat = (rd_stat ? '0 : r.stat) | ev_set;
		next_r.irq = |(next_r.stat & r.mask);
	end

	////////////////////////////////////////////////////////////////////
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r <= '0;
			r.ctrl <= {19'h0, RST_DLY, RST_AUX, 5'h00, RST_MODE};
			r.st <= TCQ_S_IDLE;
		end else begin
			r <= next_r;
		end
	end

	// trace memory keeps no reset; only wptr says what is valid
	always_ff @(posedge pclk) begin
		if (r.we) begin
			mem[r.wptr - 1'b1] <= r.rec;
		end
	end

	////////////////////////////////////////////////////////////////////
	assign prdata = r.prdata;
	assign pready = r.pready;
	assign pslverr = r.pslverr;
	assign trace_we = r.we;
	assign trace_rec = r.rec;
	assign halt = r.halt;
	assign irq = r.irq;
endmodule // tcq_top
`default_nettype wire
